// ---- design/vpf_filter.sv ----
// Purpose: vlan admission and private vlan forwarding mask
// Assumes: frm_src_port and egr_port below NPORTS, NPORTS up to 32
// Notes: apb slave with no wait states; results one cycle after request
`timescale 1ns/10ps
`default_nettype none
module vpf_filter
#(
    parameter int NPORTS = vpf_pkg::NPORTS_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frm_valid,
    input wire logic [$clog2(NPORTS)-1:0] frm_src_port,
    input wire logic frm_tagged,
    input wire logic [11:0] frm_vid,
    output logic res_valid,
    output logic res_drop,
    output logic [NPORTS-1:0] res_fwd_mask,
    output logic [11:0] res_vid,
    input wire logic egr_valid,
    input wire logic [$clog2(NPORTS)-1:0] egr_port,
    input wire logic [11:0] egr_vid,
    output logic egr_rvalid,
    output logic egr_tagged
);
    localparam int PW = $clog2(NPORTS);
    localparam logic [7:0] NP8 = 8'(NPORTS);

    logic [vpf_pkg::CFG_W-1:0] pcfg [NPORTS];
    logic [11:0] egress_untagged_vlan_id [NPORTS];
    logic [NPORTS-1:0] cfg_we, egress_untagged_vlan_id_we, iso_v;
    logic [NPORTS-1:0] vlan_mem [vpf_pkg::NVID];
    logic [vpf_pkg::NVID-1:0] vlan_vld_q, vlan_vld_d;
    logic [NPORTS-1:0] pv_mask_q [NPORTS];
    logic [NPORTS-1:0] pv_mask_d [NPORTS];
    logic [NPORTS-1:0] pv_vld_q, pv_vld_d;
    logic [PW-1:0] port_sel_q, port_sel_d;
    logic [11:0] vlan_sel_q, vlan_sel_d;
    logic [7:0] pv_sel_q, pv_sel_d;
    logic [PW-1:0] pv_idx;
    logic pv_ok, vlan_ok, vlan_we, err_q, err_d;
    logic [15:0] drop_cnt_q, drop_cnt_d;
    logic [31:0] prdata_d;
    logic [31:0] prdata_q;
    logic wr, rd_setup, hit;
    logic [11:0] cls_vid;
    logic [NPORTS-1:0] raw, memb, common, fwd;
    logic drop;
    logic res_valid_d, res_drop_d;
    logic [NPORTS-1:0] res_fwd_d;
    logic [11:0] res_vid_d;
    logic egr_tag_d;

    genvar g;
    generate
        for (g = 0; g < NPORTS; g++)
        begin : gen_port
            vpf_port_cfg u_cfg
            (
                .pclk(pclk),
                .presetn(presetn),
                .cfg_we(cfg_we[g]),
                .egress_untagged_vlan_id_we(egress_untagged_vlan_id_we[g]),
                .wdata(pwdata),
                .cfg_q(pcfg[g]),
                .egress_untagged_vlan_id_q(egress_untagged_vlan_id[g])
            );
            assign iso_v[g] = pcfg[g][vpf_pkg::CFG_ISO];
        end
    endgenerate

    // never-written vlan 1 reads as all ports
    function automatic logic [NPORTS-1:0] vlan_rd(input logic [11:0] v);
        logic [NPORTS-1:0] m;
        m = '0;
        if (vlan_vld_q[v])
            m = vlan_mem[v];
        else if (v == vpf_pkg::VID_DEF)
            m = '1;
        return m;
    endfunction

    function automatic logic [31:0] ext(input logic [NPORTS-1:0] m);
        return {{(32 - NPORTS){1'b0}}, m};
    endfunction

    assign pready = 1'b1;
    assign prdata = prdata_q;

    // apb decode and configuration updates
    always_comb
    begin
        wr = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        pv_ok = (pv_sel_q >= vpf_pkg::PV_DEF) && (pv_sel_q <= NP8);
        pv_idx = PW'(pv_sel_q - 8'h01);
        vlan_ok = (vlan_sel_q >= vpf_pkg::VID_MIN)
            && (vlan_sel_q <= vpf_pkg::VID_MAX);
        port_sel_d = port_sel_q;
        vlan_sel_d = vlan_sel_q;
        pv_sel_d = pv_sel_q;
        vlan_vld_d = vlan_vld_q;
        pv_vld_d = pv_vld_q;
        pv_mask_d = pv_mask_q;
        cfg_we = '0;
        egress_untagged_vlan_id_we = '0;
        vlan_we = 1'b0;
        err_d = err_q;
        hit = 1'b1;
        prdata_d = prdata_q;
        case (paddr)
            vpf_pkg::A_PORT_SEL: prdata_d = 32'(port_sel_q);
            vpf_pkg::A_PORT_CFG: prdata_d = 32'(pcfg[port_sel_q]);
            vpf_pkg::A_PORT_EGRESS_UNTAGGED_VLAN_ID: prdata_d = 32'(egress_untagged_vlan_id[port_sel_q]);
            vpf_pkg::A_VLAN_SEL: prdata_d = 32'(vlan_sel_q);
            vpf_pkg::A_VLAN_MASK: prdata_d = ext(vlan_rd(vlan_sel_q));
            vpf_pkg::A_PV_SEL: prdata_d = 32'(pv_sel_q);
            vpf_pkg::A_PV_MASK:
                prdata_d = pv_ok ? ext(pv_mask_q[pv_idx]) : 32'h0000_0000;
            vpf_pkg::A_PV_CMD:
                prdata_d = 32'(pv_ok && pv_vld_q[pv_idx]);
            vpf_pkg::A_STATUS:
                prdata_d = {drop_cnt_q, 15'h0000, err_q};
            default:
            begin
                prdata_d = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
        if (!rd_setup)
            prdata_d = prdata_q;
        if (wr)
        begin
            case (paddr)
                vpf_pkg::A_PORT_SEL:
                    if (pwdata < 32'(NPORTS))
                        port_sel_d = pwdata[PW-1:0];
                    else
                        err_d = 1'b1;
                vpf_pkg::A_PORT_CFG: cfg_we[port_sel_q] = 1'b1;
                vpf_pkg::A_PORT_EGRESS_UNTAGGED_VLAN_ID: egress_untagged_vlan_id_we[port_sel_q] = 1'b1;
                vpf_pkg::A_VLAN_SEL: vlan_sel_d = pwdata[11:0];
                vpf_pkg::A_VLAN_MASK:
                    if (vlan_ok)
                    begin
                        vlan_we = 1'b1;
                        vlan_vld_d[vlan_sel_q] = 1'b1;
                    end
                    else
                        err_d = 1'b1;
                vpf_pkg::A_PV_SEL: pv_sel_d = pwdata[7:0];
                vpf_pkg::A_PV_MASK:
                    if (pv_ok && pv_vld_q[pv_idx])
                        pv_mask_d[pv_idx] = pwdata[NPORTS-1:0];
                    else
                        err_d = 1'b1;
                vpf_pkg::A_PV_CMD:
                    if (!pv_ok)
                        err_d = 1'b1;
                    else if (pwdata[vpf_pkg::CMD_CREATE])
                    begin
                        pv_vld_d[pv_idx] = 1'b1;
                        pv_mask_d[pv_idx] = '0;
                    end
                    else if (pwdata[vpf_pkg::CMD_DELETE])
                        pv_vld_d[pv_idx] = 1'b0;
                vpf_pkg::A_STATUS:
                    if (pwdata[vpf_pkg::ST_ERR])
                        err_d = 1'b0;
                default: err_d = err_q;
            endcase
        end
        // a rejected vlan mask or pv cmd write keeps the flag set
        if (wr && ((paddr == vpf_pkg::A_VLAN_MASK && !vlan_ok)
            || ((paddr == vpf_pkg::A_PV_CMD) && !pv_ok)))
            err_d = 1'b1;
    end

    assign pslverr = psel && penable && !hit;

    // ingress admission and forwarding mask
    always_comb
    begin
        cls_vid = (frm_tagged && pcfg[frm_src_port][vpf_pkg::CFG_AWARE])
            ? frm_vid : pcfg[frm_src_port][11:0];
        raw = vlan_rd(cls_vid);
        common = '0;
        for (int p = 0; p < NPORTS; p++)
        begin
            memb[p] = raw[p] && (pcfg[p][vpf_pkg::CFG_AWARE]
                || pcfg[p][11:0] == cls_vid);
            if (pv_vld_q[p] && pv_mask_q[p][frm_src_port])
                common = common | pv_mask_q[p];
        end
        drop = (pcfg[frm_src_port][vpf_pkg::CFG_FILT]
            && !memb[frm_src_port])
            || (pcfg[frm_src_port][vpf_pkg::CFG_TAGONLY] && !frm_tagged)
            || (cls_vid == 12'h000);
        fwd = memb & common;
        if (iso_v[frm_src_port])
            fwd = fwd & ~iso_v;
        fwd[frm_src_port] = 1'b0;
        if (drop)
            fwd = '0;
        res_valid_d = frm_valid;
        res_drop_d = frm_valid ? drop : res_drop;
        res_fwd_d = frm_valid ? fwd : res_fwd_mask;
        res_vid_d = frm_valid ? cls_vid : res_vid;
        drop_cnt_d = drop_cnt_q + 16'((frm_valid && drop) ? 1 : 0);
        egr_tag_d = egr_valid ? (egr_vid != egress_untagged_vlan_id[egr_port])
            : egr_tagged;
    end

    always_ff @(posedge pclk)
    begin
        if (vlan_we)
            vlan_mem[vlan_sel_q] <= pwdata[NPORTS-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_sel_q <= '0;
            vlan_sel_q <= vpf_pkg::VID_DEF;
            pv_sel_q <= vpf_pkg::PV_DEF;
            vlan_vld_q <= '0;
            pv_vld_q <= NPORTS'(1);
            for (int p = 0; p < NPORTS; p++)
                pv_mask_q[p] <= (p == 0) ? '1 : '0;
            err_q <= 1'b0;
            drop_cnt_q <= 16'h0000;
            prdata_q <= 32'h0000_0000;
            res_valid <= 1'b0;
            res_drop <= 1'b0;
            res_fwd_mask <= '0;
            res_vid <= 12'h000;
            egr_rvalid <= 1'b0;
            egr_tagged <= 1'b0;
        end
        else
        begin
            port_sel_q <= port_sel_d;
            vlan_sel_q <= vlan_sel_d;
            pv_sel_q <= pv_sel_d;
            vlan_vld_q <= vlan_vld_d;
            pv_vld_q <= pv_vld_d;
            pv_mask_q <= pv_mask_d;
            err_q <= err_d;
            drop_cnt_q <= drop_cnt_d;
            prdata_q <= prdata_d;
            res_valid <= res_valid_d;
            res_drop <= res_drop_d;
            res_fwd_mask <= res_fwd_d;
            res_vid <= res_vid_d;
            egr_rvalid <= egr_valid;
            egr_tagged <= egr_tag_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_filt;
        frm_valid && pcfg[frm_src_port][vpf_pkg::CFG_FILT]
            && !memb[frm_src_port] |=> res_valid && res_drop;
    endproperty
    a_filt: assert property (p_filt) else $error("filtered frame kept");

    property p_tagonly;
        frm_valid && !frm_tagged
            && pcfg[frm_src_port][vpf_pkg::CFG_TAGONLY] |=> res_drop;
    endproperty
    a_tagonly: assert property (p_tagonly) else $error("untagged kept");

    property p_egress_untagged_vlan_id;
        egr_valid |=> egr_rvalid
            && egr_tagged == ($past(egr_vid) != $past(egress_untagged_vlan_id[egr_port]));
    endproperty
    a_egress_untagged_vlan_id: assert property (p_egress_untagged_vlan_id) else $error("egress tag wrong");

    property p_nosrc;
        frm_valid |=> !res_fwd_mask[$past(frm_src_port)];
    endproperty
    a_nosrc: assert property (p_nosrc) else $error("source forwarded");

    property p_iso;
        frm_valid && iso_v[frm_src_port]
            |=> (res_fwd_mask & $past(iso_v)) == '0;
    endproperty
    a_iso: assert property (p_iso) else $error("iso to iso");

    property p_subset;
        frm_valid |=> (res_fwd_mask & ~$past(memb & common)) == '0;
    endproperty
    a_subset: assert property (p_subset) else $error("mask widened");

    property p_port_default_vlan_id;
        frm_valid && !frm_tagged
            |=> res_vid == $past(pcfg[frm_src_port][11:0]);
    endproperty
    a_port_default_vlan_id: assert property (p_port_default_vlan_id) else $error("bad classify");

    property p_pvrange;
        wr && paddr == vpf_pkg::A_PV_CMD && !pv_ok
            |=> err_q && $stable(pv_vld_q);
    endproperty
    a_pvrange: assert property (p_pvrange) else $error("bad id taken");

    property p_pvnew;
        wr && paddr == vpf_pkg::A_PV_CMD && pv_ok
            && pwdata[vpf_pkg::CMD_CREATE]
            |=> pv_mask_q[$past(pv_idx)] == '0;
    endproperty
    a_pvnew: assert property (p_pvnew) else $error("new pvlan not empty");

    property p_vid0;
        wr && paddr == vpf_pkg::A_VLAN_MASK && vlan_sel_q == 12'h000
            |=> err_q && !vlan_vld_q[0];
    endproperty
    a_vid0: assert property (p_vid0) else $error("vid 0 taken");

    c_drop: cover property (frm_valid ##1 res_drop);
    c_fwd: cover property (frm_valid ##1 res_fwd_mask != '0);
    c_iso: cover property (frm_valid && iso_v[frm_src_port]
        ##1 res_fwd_mask != '0);
    c_tag: cover property (egr_valid ##1 egr_tagged);
endmodule
`default_nettype wire

// ---- design/vpf_pkg.sv ----
// Purpose: constants for the vlan port forward filter
// Assumes: ports are numbered 0..NPORTS-1, private vlan ids 1..NPORTS
// Notes: byte addresses of the apb registers, fields and reset values
// Function
// - filtering drops frames from non-member ports
// - tagged-only ports drop untagged frames
// - per-port untagged vid selects egress tagging
// - forward needs common vlan and private vlan
// - reset: unaware, vlan 1, private vlan 1
// - unaware port belongs to one vlan only
// - private vlan masks independent of vlan table
// - private vlan id outside port range rejected
// - new private vlan starts with empty mask
// - promiscuous source uses vlan membership mask
// - isolated source narrowed to promiscuous ports
// - isolated port never receives isolated traffic
// - isolation is one attribute per port
// - isolation bit per port, clear at reset
// - untagged frame classified to port default vid
// - vlan table accepts ids 1 to 4095
package vpf_pkg;
    localparam int NPORTS_DEF = 10;
    localparam int VID_W = 12;
    localparam int NVID = 4096;
    localparam logic [11:0] A_PORT_SEL = 12'h000;
    localparam logic [11:0] A_PORT_CFG = 12'h004;
    localparam logic [11:0] A_PORT_EGRESS_UNTAGGED_VLAN_ID = 12'h008;
    localparam logic [11:0] A_VLAN_SEL = 12'h00c;
    localparam logic [11:0] A_VLAN_MASK = 12'h010;
    localparam logic [11:0] A_PV_SEL = 12'h014;
    localparam logic [11:0] A_PV_MASK = 12'h018;
    localparam logic [11:0] A_PV_CMD = 12'h01c;
    localparam logic [11:0] A_STATUS = 12'h020;
    localparam int CFG_W = 16;
    localparam int CFG_FILT = 12;
    localparam int CFG_TAGONLY = 13;
    localparam int CFG_ISO = 14;
    localparam int CFG_AWARE = 15;
    localparam int CMD_CREATE = 0;
    localparam int CMD_DELETE = 1;
    localparam int ST_ERR = 0;
    localparam int ST_DROP_LSB = 16;
    localparam logic [15:0] CFG_RST = 16'h0001;
    localparam logic [11:0] EGRESS_UNTAGGED_VLAN_ID_RST = 12'h001;
    localparam logic [11:0] VID_DEF = 12'h001;
    localparam logic [11:0] VID_MIN = 12'h001;
    localparam logic [11:0] VID_MAX = 12'hfff;
    localparam logic [7:0] PV_DEF = 8'h01;
endpackage

// ---- design/vpf_port_cfg.sv ----
// Purpose: configuration of one switch port
// Assumes: writes come from the apb decode of the filter
// Notes: cfg holds default vid, filter, tagged-only, isolate, aware
`timescale 1ns/10ps
`default_nettype none
module vpf_port_cfg
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cfg_we,
    input wire logic egress_untagged_vlan_id_we,
    input wire logic [31:0] wdata,
    output logic [vpf_pkg::CFG_W-1:0] cfg_q,
    output logic [vpf_pkg::VID_W-1:0] egress_untagged_vlan_id_q
);
    logic [vpf_pkg::CFG_W-1:0] cfg_d;
    logic [vpf_pkg::VID_W-1:0] egress_untagged_vlan_id_d;

    always_comb
    begin
        cfg_d = cfg_we ? wdata[vpf_pkg::CFG_W-1:0] : cfg_q;
        egress_untagged_vlan_id_d = egress_untagged_vlan_id_we ? wdata[vpf_pkg::VID_W-1:0] : egress_untagged_vlan_id_q;
    end

    // unaware, vlan 1, isolation off out of reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= vpf_pkg::CFG_RST;
            egress_untagged_vlan_id_q <= vpf_pkg::EGRESS_UNTAGGED_VLAN_ID_RST;
        end
        else
        begin
            cfg_q <= cfg_d;
            egress_untagged_vlan_id_q <= egress_untagged_vlan_id_d;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/vpf_station.sv ----
// Purpose: station model issuing frame lookups and egress queries
// Assumes: one request in flight, answer within four cycles
// Notes: request fields are inverted once the request has been taken
`timescale 1ns/10ps
`default_nettype none
module vpf_station
(
    input wire logic pclk,
    input wire logic res_valid,
    input wire logic egr_rvalid,
    output logic frm_valid,
    output logic [3:0] frm_src_port,
    output logic frm_tagged,
    output logic [11:0] frm_vid,
    output logic egr_valid,
    output logic [3:0] egr_port,
    output logic [11:0] egr_vid
);
    initial
    begin
        frm_valid = 1'b0;
        frm_src_port = 4'h0;
        frm_tagged = 1'b0;
        frm_vid = 12'h000;
        egr_valid = 1'b0;
        egr_port = 4'h0;
        egr_vid = 12'h000;
    end

    task automatic send(input logic [3:0] p, input logic t,
        input logic [11:0] v, output logic ok);
        @(posedge pclk);
        frm_valid <= 1'b1;
        frm_src_port <= p;
        frm_tagged <= t;
        frm_vid <= v;
        @(posedge pclk);
        frm_valid <= 1'b0;
        frm_src_port <= ~p;
        frm_tagged <= ~t;
        frm_vid <= ~v;
        ok = 1'b0;
        for (int n = 0; n < 4 && ok !== 1'b1; n++)
        begin
            @(negedge pclk);
            ok = res_valid;
        end
    endtask

    task automatic query(input logic [3:0] p, input logic [11:0] v,
        output logic ok);
        @(posedge pclk);
        egr_valid <= 1'b1;
        egr_port <= p;
        egr_vid <= v;
        @(posedge pclk);
        egr_valid <= 1'b0;
        egr_port <= ~p;
        egr_vid <= ~v;
        ok = 1'b0;
        for (int n = 0; n < 4 && ok !== 1'b1; n++)
        begin
            @(negedge pclk);
            ok = egr_rvalid;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the vlan port forward filter
// Assumes: ten ports, apb slave raises pready
// Notes: frames come from the station model
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int NP = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, d;
    logic pready, pslverr, e, ok;
    logic frm_valid, frm_tagged, res_valid, res_drop;
    logic egr_valid, egr_rvalid, egr_tagged;
    logic [3:0] frm_src_port, egr_port;
    logic [11:0] frm_vid, res_vid, egr_vid;
    logic [9:0] res_fwd_mask;
    logic [31:0] pv_ids [3] = '{32'h0000_0000, 32'h0000_000b, 32'h0000_0003};
    logic pv_err [3] = '{1'b1, 1'b1, 1'b0};
    int fails = 0;
    int comparisons = 0;

    always #10 pclk = ~pclk;

    vpf_filter #(.NPORTS(NP)) DUT
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
        .frm_src_port(frm_src_port), .frm_tagged(frm_tagged),
        .frm_vid(frm_vid), .res_valid(res_valid), .res_drop(res_drop),
        .res_fwd_mask(res_fwd_mask), .res_vid(res_vid),
        .egr_valid(egr_valid), .egr_port(egr_port), .egr_vid(egr_vid),
        .egr_rvalid(egr_rvalid), .egr_tagged(egr_tagged)
    );

    vpf_station st
    (
        .pclk(pclk), .res_valid(res_valid), .egr_rvalid(egr_rvalid),
        .frm_valid(frm_valid), .frm_src_port(frm_src_port),
        .frm_tagged(frm_tagged), .frm_vid(frm_vid), .egr_valid(egr_valid),
        .egr_port(egr_port), .egr_vid(egr_vid)
    );

    task automatic chk(input string s, input logic [31:0] x,
        input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            fails++;
            $display("MISMATCH %s exp %h got %h", s, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] v);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h0000_0001, {31'h0, pready});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), x, d);
    endtask

    // reads the sticky error bit, then clears it
    task automatic errchk(input logic x);
        apb(1'b0, vpf_pkg::A_STATUS, 32'h0000_0000);
        chk("status err", {31'h0, x}, {31'h0, d[0]});
        wr(vpf_pkg::A_STATUS, 32'h0000_0001);
    endtask

    task automatic fr(input logic [3:0] p, input logic t, input logic [11:0] v,
        input logic xd, input logic [9:0] xm, input logic [11:0] xv);
        st.send(p, t, v, ok);
        chk("res_valid", 32'h0000_0001, {31'h0, ok});
        chk("res_drop", {31'h0, xd}, {31'h0, res_drop});
        chk("res_fwd_mask", {22'h0, xm}, {22'h0, res_fwd_mask});
        chk("res_vid", {20'h0, xv}, {20'h0, res_vid});
    endtask

    task automatic eg(input logic [3:0] p, input logic [11:0] v, input logic x);
        st.query(p, v, ok);
        chk("egr_rvalid", 32'h0000_0001, {31'h0, ok});
        chk("egr_tagged", {31'h0, x}, {31'h0, egr_tagged});
    endtask

    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        stop_test;
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rc(vpf_pkg::A_PORT_CFG, 32'h0000_0001);
        rc(vpf_pkg::A_PORT_EGRESS_UNTAGGED_VLAN_ID, 32'h0000_0001);
        rc(vpf_pkg::A_VLAN_MASK, 32'h0000_03ff);
        rc(vpf_pkg::A_PV_MASK, 32'h0000_03ff);
        fr(4'h2, 1'b0, 12'h007, 1'b0, 10'h3fb, 12'h001);
        fr(4'h2, 1'b1, 12'h005, 1'b0, 10'h3fb, 12'h001);
        wr(vpf_pkg::A_PORT_SEL, 32'h0000_0001);
        wr(vpf_pkg::A_PORT_CFG, 32'h0000_2001);
        fr(4'h1, 1'b0, 12'h000, 1'b1, 10'h000, 12'h001);
        fr(4'h1, 1'b1, 12'h005, 1'b0, 10'h3fd, 12'h001);
        wr(vpf_pkg::A_PORT_CFG, 32'h0000_9005);
        fr(4'h1, 1'b1, 12'h005, 1'b1, 10'h000, 12'h005);
        wr(vpf_pkg::A_PORT_SEL, 32'h0000_0002);
        wr(vpf_pkg::A_PORT_CFG, 32'h0000_8001);
        wr(vpf_pkg::A_VLAN_SEL, 32'h0000_0005);
        wr(vpf_pkg::A_VLAN_MASK, 32'h0000_0006);
        fr(4'h1, 1'b1, 12'h005, 1'b0, 10'h004, 12'h005);
        fr(4'h1, 1'b0, 12'h000, 1'b0, 10'h004, 12'h005);
        rc(vpf_pkg::A_STATUS, 32'h0002_0000);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk("unmapped pslverr", 32'h0000_0001, {31'h0, e});
        chk("unmapped prdata", 32'h0000_0000, d);
        wr(vpf_pkg::A_VLAN_SEL, 32'h0000_0000);
        wr(vpf_pkg::A_VLAN_MASK, 32'h0000_0001);
        errchk(1'b1);
        wr(vpf_pkg::A_VLAN_SEL, 32'h0000_0fff);
        wr(vpf_pkg::A_VLAN_MASK, 32'h0000_0001);
        rc(vpf_pkg::A_VLAN_MASK, 32'h0000_0001);
        foreach (pv_ids[i])
        begin
            wr(vpf_pkg::A_PV_SEL, pv_ids[i]);
            wr(vpf_pkg::A_PV_CMD, 32'h0000_0001);
            errchk(pv_err[i]);
        end
        rc(vpf_pkg::A_PV_CMD, 32'h0000_0001);
        rc(vpf_pkg::A_PV_MASK, 32'h0000_0000);
        wr(vpf_pkg::A_PV_MASK, 32'h0000_0005);
        wr(vpf_pkg::A_PV_SEL, 32'h0000_0001);
        wr(vpf_pkg::A_PV_CMD, 32'h0000_0002);
        rc(vpf_pkg::A_PV_CMD, 32'h0000_0000);
        wr(vpf_pkg::A_PV_MASK, 32'h0000_03ff);
        errchk(1'b1);
        fr(4'h0, 1'b0, 12'h000, 1'b0, 10'h004, 12'h001);
        fr(4'h4, 1'b0, 12'h000, 1'b0, 10'h000, 12'h001);
        wr(vpf_pkg::A_VLAN_SEL, 32'h0000_0003);
        rc(vpf_pkg::A_VLAN_MASK, 32'h0000_0000);
        wr(vpf_pkg::A_PV_SEL, 32'h0000_0003);
        wr(vpf_pkg::A_PV_MASK, 32'h0000_000d);
        wr(vpf_pkg::A_PORT_CFG, 32'h0000_c001);
        wr(vpf_pkg::A_PORT_SEL, 32'h0000_0003);
        wr(vpf_pkg::A_PORT_CFG, 32'h0000_4001);
        fr(4'h2, 1'b0, 12'h000, 1'b0, 10'h001, 12'h001);
        fr(4'h0, 1'b0, 12'h000, 1'b0, 10'h00c, 12'h001);
        wr(vpf_pkg::A_PV_SEL, 32'h0000_000a);
        wr(vpf_pkg::A_PV_CMD, 32'h0000_0001);
        wr(vpf_pkg::A_PV_MASK, 32'h0000_000c);
        fr(4'h3, 1'b0, 12'h000, 1'b0, 10'h001, 12'h001);
        wr(vpf_pkg::A_PORT_SEL, 32'h0000_0004);
        wr(vpf_pkg::A_PORT_EGRESS_UNTAGGED_VLAN_ID, 32'h0000_0005);
        eg(4'h4, 12'h005, 1'b0);
        eg(4'h4, 12'h001, 1'b1);
        eg(4'h5, 12'h001, 1'b0);
        stop_test;
    end
endmodule
`default_nettype wire
